// File: logic/can_mode_ctrl.sv
// mode control, init/sleep handshakes, write locks and bit-timing settings
`timescale 1ns/1ps
`include "can_mode_consts.svh"

// Functional notes
// - sleep only when receiver idle, transmit empty
// - sleep ack set on entry
// - wake by cpu clear or bus activity
// - sleep request held until sleep acknowledged
// - init request aborts traffic, then acknowledges
// - init mode resets listed registers
// - config registers writable only in init
// - error counters untouched by init
// - resync after 11 recessive, bus-off 128 runs
// - init request held until init acknowledged
// - transmit pin recessive at init request
// - module enable write-once outside special mode
// - clock select picks bus or oscillator
// - loopback feeds tx to rx, pin recessive
// - listen-only: no ack, errors, transmit
// - wake filter needs long dominant pulse
// - jump width is field plus one
// - prescaler divisor is field plus one
// - timing regs read anytime, reset zero
// - wake enable zero ignores bus traffic
module can_mode_ctrl
  import can_mode_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         srst,
  input  wire reg_req_s     req,
  output logic [7:0]        rdata,
  input  wire core_status_s core,
  input  wire logic         special_mode,
  input  wire logic         bus_rx_pin,
  output logic              bus_tx_pin,
  output logic              rx_bit,
  output logic              tq_tick,
  output logic [2:0]        resync_jump_width,
  output logic              triple_sampling,
  output logic [2:0]        phase_segment_two,
  output logic [3:0]        phase_segment_one,
  output logic              clock_select,
  output logic              module_enable,
  output logic              abort_traffic,
  output logic              synced,
  output logic              ack_suppress,
  output logic              err_freeze,
  output logic              tx_inhibit
);

  // ==========================================================
  // helpers
  function automatic logic in_init(input logic [7:0] c0, input logic [7:0] c1);
    in_init = c0[`CTL0_INIT_REQ] & c1[`CTL1_INIT_ACK];
  endfunction

  // ==========================================================
  // registers
  logic [7:0]  ctl0_q;
  logic [7:0]  ctl1_q;
  logic [7:0]  btr0_q;
  logic [7:0]  btr1_q;
  logic [7:0]  rflg_q;
  logic [7:0]  rier_q;
  logic [7:0]  tflg_q;
  logic [7:0]  tier_q;
  logic [7:0]  tarq_q;
  logic [7:0]  tbsel_q;
  logic [7:0]  idac_q;
  logic [7:0]  acc_q [16];
  logic        mod_en_locked_q;
  mode_state_e state_q;
  logic [5:0]  tq_cnt_q;
  logic [3:0]  rec_run_q;
  logic [7:0]  rec_seq_q;
  logic        rx_prev_q;
  logic [6:0]  wake_cnt_q;
  logic        wake_hit;
  logic        init_mode;
  logic        wr;
  logic        rx_line;

  assign init_mode = in_init(ctl0_q, ctl1_q);
  assign wr        = req.wr;
  // loopback ignores the pin and listens to our own transmitter
  assign rx_line   = ctl1_q[`CTL1_LOOPBACK] ? core.tx_bit : bus_rx_pin;

  // ==========================================================
  // mode state machine
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= ST_INIT;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (ctl0_q[`CTL0_INIT_REQ])
            state_q <= ST_INIT;
          else if (ctl0_q[`CTL0_SLEEP_REQ])
            state_q <= ST_SLEEPWT;
        end
        ST_SLEEPWT: begin
          if (ctl0_q[`CTL0_INIT_REQ])
            state_q <= ST_INIT;
          else if (!ctl0_q[`CTL0_SLEEP_REQ])
            state_q <= ST_RUN;
          else if (!core.rx_busy && !core.tx_pending)
            state_q <= ST_SLEEP;
        end
        ST_SLEEP: begin
          if (ctl0_q[`CTL0_INIT_REQ])
            state_q <= ST_INIT;
          else if (!ctl0_q[`CTL0_SLEEP_REQ] || wake_hit)
            state_q <= ST_RUN;
        end
        ST_INIT: begin
          // the ack drops one cycle after we leave, so it cannot gate the exit
          if (!ctl0_q[`CTL0_INIT_REQ])
            state_q <= ST_RESYNC;
        end
        ST_RESYNC: begin
          if (ctl0_q[`CTL0_INIT_REQ])
            state_q <= ST_INIT;
          else if (rec_run_q == `RECESSIVE_RUN &&
                   (!core.bus_off || rec_seq_q == `BUSOFF_RUNS))
            state_q <= ST_RUN;
        end
        default: state_q <= ST_INIT;
      endcase
    end
  end

  // ==========================================================
  // recessive run counter, counted in bit times
  // limitation: one recessive sample per tq tick stands in for a bit time
  always_ff @(posedge mclk) begin
    if (srst || state_q != ST_RESYNC) begin
      rec_run_q <= 4'h0;
      rec_seq_q <= 8'h00;
    end else if (tq_tick) begin
      if (!rx_line) begin
        rec_run_q <= 4'h0;
      end else if (rec_run_q == `RECESSIVE_RUN) begin
        // this bit opens the next run; runs are counted only when complete
        rec_run_q <= 4'h1;
      end else begin
        rec_run_q <= rec_run_q + 4'h1;
        if (rec_run_q == `RECESSIVE_RUN - 4'h1)
          rec_seq_q <= (rec_seq_q == `BUSOFF_RUNS) ? rec_seq_q : rec_seq_q + 8'h01;
      end
    end
  end

  // ==========================================================
  // wake detection in sleep
  always_ff @(posedge mclk) begin
    if (srst) begin
      rx_prev_q  <= 1'b1;
      wake_cnt_q <= 7'h00;
    end else begin
      rx_prev_q <= rx_line;
      if (state_q != ST_SLEEP || rx_line)
        wake_cnt_q <= 7'h00;
      else if (wake_cnt_q != 7'(`WAKE_FILTER_CYC))
        wake_cnt_q <= wake_cnt_q + 7'h01;
    end
  end

  always_comb begin
    wake_hit = 1'b0;
    if (ctl0_q[`CTL0_WAKE_EN]) begin
      if (ctl1_q[`CTL1_WAKE_FILT])
        wake_hit = (wake_cnt_q == 7'(`WAKE_FILTER_CYC));
      else
        wake_hit = rx_prev_q && !rx_line;
    end
  end

  // ==========================================================
  // primary control
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctl0_q <= `RST_CTL0;
    end else begin
      if (init_mode)
        ctl0_q <= ctl0_q & `CTL0_KEEP_MASK;
      else begin
        ctl0_q[`CTL0_SYNCED]    <= (state_q == ST_RUN || state_q == ST_SLEEPWT);
        ctl0_q[`CTL0_RX_ACTIVE] <= core.rx_busy;
      end
      if (wr && req.addr == `OFS_CTL_PRIMARY) begin
        if (!init_mode) begin
          ctl0_q[`CTL0_STOP_WAIT] <= req.wdata[`CTL0_STOP_WAIT];
          ctl0_q[`CTL0_TIMER_EN]  <= req.wdata[`CTL0_TIMER_EN];
          if (req.wdata[`CTL0_RX_FRAME])
            ctl0_q[`CTL0_RX_FRAME] <= 1'b0;
        end
        ctl0_q[`CTL0_WAKE_EN] <= req.wdata[`CTL0_WAKE_EN];
        // a request clears only once its mode is acknowledged
        if (req.wdata[`CTL0_INIT_REQ] || ctl1_q[`CTL1_INIT_ACK])
          ctl0_q[`CTL0_INIT_REQ] <= req.wdata[`CTL0_INIT_REQ];
        if (req.wdata[`CTL0_SLEEP_REQ] || ctl1_q[`CTL1_SLEEP_ACK])
          ctl0_q[`CTL0_SLEEP_REQ] <= req.wdata[`CTL0_SLEEP_REQ];
      end
      if (state_q == ST_SLEEP && wake_hit)
        ctl0_q[`CTL0_SLEEP_REQ] <= 1'b0;
    end
  end

  // ==========================================================
  // secondary control and acknowledges
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctl1_q          <= `RST_CTL1;
      mod_en_locked_q <= 1'b0;
    end else begin
      // acks follow the settled state, one cycle after it
      ctl1_q[`CTL1_INIT_ACK]  <= (state_q == ST_INIT);
      ctl1_q[`CTL1_SLEEP_ACK] <= (state_q == ST_SLEEP) && !wake_hit;
      if (wr && req.addr == `OFS_CTL_SECONDARY && init_mode) begin
        ctl1_q[`CTL1_CLK_SEL]   <= req.wdata[`CTL1_CLK_SEL];
        ctl1_q[`CTL1_LOOPBACK]  <= req.wdata[`CTL1_LOOPBACK];
        ctl1_q[`CTL1_LISTEN]    <= req.wdata[`CTL1_LISTEN];
        ctl1_q[`CTL1_WAKE_FILT] <= req.wdata[`CTL1_WAKE_FILT];
        if (special_mode || !mod_en_locked_q) begin
          ctl1_q[`CTL1_MOD_EN] <= req.wdata[`CTL1_MOD_EN];
          mod_en_locked_q      <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // bit timing and acceptance configuration
  always_ff @(posedge mclk) begin
    if (srst) begin
      btr0_q <= `RST_BT_PRESCALE;
      btr1_q <= `RST_BT_SEGMENTS;
      idac_q <= `RST_ZERO;
      for (int i = 0; i < 16; i++)
        acc_q[i] <= `RST_ZERO;
    end else if (wr && init_mode) begin
      if (req.addr == `OFS_BT_PRESCALE)
        btr0_q <= req.wdata;
      else if (req.addr == `OFS_BT_SEGMENTS)
        btr1_q <= req.wdata;
      else if (req.addr == `OFS_ACC_CTRL)
        idac_q <= req.wdata;
      else if (req.addr >= `OFS_ACC_BASE && req.addr <= `OFS_ACC_LAST)
        acc_q[req.addr[3:0]] <= req.wdata;
    end
  end

  // ==========================================================
  // flag and enable registers reset by init mode, bus-state bits of rflg_q and rier_q kept
  always_ff @(posedge mclk) begin
    if (srst) begin
      rflg_q  <= `RST_ZERO;
      rier_q  <= `RST_ZERO;
      tflg_q  <= `RST_TFLG;
      tier_q  <= `RST_ZERO;
      tarq_q  <= `RST_ZERO;
      tbsel_q <= `RST_ZERO;
    end else if (init_mode) begin
      rflg_q  <= rflg_q & `RFLG_STATE_MASK;
      rier_q  <= rier_q & `RFLG_STATE_MASK;
      tflg_q  <= `RST_TFLG;
      tier_q  <= `RST_ZERO;
      tarq_q  <= `RST_ZERO;
      tbsel_q <= `RST_ZERO;
    end else begin
      // set wins over a same-cycle clear
      if (wr && req.addr == `OFS_RX_FLAGS && req.wdata[`RFLG_WAKE_FLAG])
        rflg_q[`RFLG_WAKE_FLAG] <= 1'b0;
      if (state_q == ST_SLEEP && wake_hit)
        rflg_q[`RFLG_WAKE_FLAG] <= 1'b1;
      if (wr && req.addr == `OFS_RX_IRQ_EN)
        rier_q <= req.wdata;
      if (wr && req.addr == `OFS_TX_IRQ_EN)
        tier_q <= req.wdata;
      if (wr && req.addr == `OFS_ABORT_REQ)
        tarq_q <= req.wdata;
      if (wr && req.addr == `OFS_TX_BUF_SEL)
        tbsel_q <= req.wdata;
    end
  end

  // ==========================================================
  // time-quantum divider
  always_ff @(posedge mclk) begin
    if (srst || state_q == ST_INIT) begin
      tq_cnt_q <= 6'h00;
      tq_tick  <= 1'b0;
    end else if (tq_cnt_q == btr0_q[5:0]) begin
      tq_cnt_q <= 6'h00;
      tq_tick  <= 1'b1;
    end else begin
      tq_cnt_q <= tq_cnt_q + 6'h01;
      tq_tick  <= 1'b0;
    end
  end

  // ==========================================================
  // outputs toward the protocol core and the pin
  always_ff @(posedge mclk) begin
    if (srst) begin
      bus_tx_pin        <= 1'b1;
      rx_bit            <= 1'b1;
      resync_jump_width <= 3'h1;
      triple_sampling   <= 1'b0;
      phase_segment_two <= 3'h0;
      phase_segment_one <= 4'h0;
      clock_select      <= 1'b0;
      module_enable     <= 1'b0;
      abort_traffic     <= 1'b1;
      synced            <= 1'b0;
      ack_suppress      <= 1'b0;
      err_freeze        <= 1'b0;
      tx_inhibit        <= 1'b1;
    end else begin
      // recessive on the raw request, not the ack
      bus_tx_pin <= ctl0_q[`CTL0_INIT_REQ] || ctl1_q[`CTL1_LOOPBACK] ||
                    state_q == ST_INIT || core.tx_bit;
      rx_bit            <= rx_line;
      resync_jump_width <= {1'b0, btr0_q[7:6]} + 3'h1;
      triple_sampling   <= btr1_q[7];
      phase_segment_two <= btr1_q[6:4];
      phase_segment_one <= btr1_q[3:0];
      clock_select      <= ctl1_q[`CTL1_CLK_SEL];
      module_enable     <= ctl1_q[`CTL1_MOD_EN];
      abort_traffic     <= ctl0_q[`CTL0_INIT_REQ] || state_q == ST_INIT;
      synced            <= ctl0_q[`CTL0_SYNCED];
      ack_suppress      <= ctl1_q[`CTL1_LISTEN] || ctl1_q[`CTL1_LOOPBACK];
      // error counters live outside; init never touches them
      err_freeze        <= ctl1_q[`CTL1_LISTEN];
      tx_inhibit        <= ctl1_q[`CTL1_LISTEN] || state_q != ST_RUN;
    end
  end

  // ==========================================================
  // read port, data one cycle after the strobe
  always_ff @(posedge mclk) begin
    if (srst) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      if (req.addr == `OFS_CTL_PRIMARY)
        rdata <= ctl0_q;
      else if (req.addr == `OFS_CTL_SECONDARY)
        rdata <= ctl1_q;
      else if (req.addr == `OFS_BT_PRESCALE)
        rdata <= btr0_q;
      else if (req.addr == `OFS_BT_SEGMENTS)
        rdata <= btr1_q;
      else if (req.addr == `OFS_RX_FLAGS)
        rdata <= rflg_q;
      else if (req.addr == `OFS_RX_IRQ_EN)
        rdata <= rier_q;
      else if (req.addr == `OFS_TX_FLAGS)
        rdata <= tflg_q;
      else if (req.addr == `OFS_TX_IRQ_EN)
        rdata <= tier_q;
      else if (req.addr == `OFS_ABORT_REQ)
        rdata <= tarq_q;
      else if (req.addr == `OFS_TX_BUF_SEL)
        rdata <= tbsel_q;
      else if (req.addr == `OFS_ACC_CTRL)
        rdata <= idac_q;
      else if (req.addr == `OFS_STATUS_EXT)
        rdata <= {5'h00, state_q};
      else if (req.addr >= `OFS_ACC_BASE && req.addr <= `OFS_ACC_LAST)
        rdata <= acc_q[req.addr[3:0]];
      else
        rdata <= 8'h00;
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule

// File: logic/can_mode_consts.svh
// offsets, field positions, reset values and timing counts of the mode/timing block
`ifndef CAN_MODE_CONSTS_SVH
`define CAN_MODE_CONSTS_SVH

// register offsets (byte addresses on the plain port)
`define OFS_CTL_PRIMARY    8'h00
`define OFS_CTL_SECONDARY  8'h01
`define OFS_BT_PRESCALE    8'h02
`define OFS_BT_SEGMENTS    8'h03
`define OFS_RX_FLAGS       8'h04
`define OFS_RX_IRQ_EN      8'h05
`define OFS_TX_FLAGS       8'h06
`define OFS_TX_IRQ_EN      8'h07
`define OFS_ABORT_REQ      8'h08
`define OFS_ABORT_ACK      8'h09
`define OFS_TX_BUF_SEL     8'h0A
`define OFS_ACC_CTRL       8'h0B
`define OFS_ACC_BASE       8'h10
`define OFS_ACC_LAST       8'h1F
`define OFS_STATUS_EXT     8'h0C

// primary control fields
`define CTL0_RX_FRAME      7
`define CTL0_RX_ACTIVE     6
`define CTL0_STOP_WAIT     5
`define CTL0_SYNCED        4
`define CTL0_TIMER_EN      3
`define CTL0_WAKE_EN       2
`define CTL0_SLEEP_REQ     1
`define CTL0_INIT_REQ      0
`define CTL0_KEEP_MASK     8'h07

// secondary control fields
`define CTL1_MOD_EN        7
`define CTL1_CLK_SEL       6
`define CTL1_LOOPBACK      5
`define CTL1_LISTEN        4
`define CTL1_WAKE_FILT     2
`define CTL1_SLEEP_ACK     1
`define CTL1_INIT_ACK      0
`define CTL1_WR_MASK       8'hF4

// receive flags: bus-state bits survive init
`define RFLG_WAKE_FLAG     7
`define RFLG_STATE_MASK    8'h3C

// reset values
`define RST_CTL0           8'h01
`define RST_CTL1           8'h11
`define RST_BT_PRESCALE    8'h00
`define RST_BT_SEGMENTS    8'h00
`define RST_TFLG           8'h07
`define RST_ZERO           8'h00

// timing
`define RECESSIVE_RUN      4'd11
`define BUSOFF_RUNS        8'd128
`define WAKE_FILTER_NS     2000
`define CLK_PERIOD_NS      50
`define WAKE_FILTER_CYC    ((`WAKE_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: logic/can_mode_pkg.sv
// types shared by the mode-control and bit-timing block
package can_mode_pkg;

  typedef enum logic [2:0] {
    ST_RUN     = 3'b000,
    ST_INIT    = 3'b001,
    ST_RESYNC  = 3'b011,
    ST_SLEEP   = 3'b010,
    ST_SLEEPWT = 3'b110
  } mode_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_s;

  typedef struct packed {
    logic       rx_busy;
    logic       tx_pending;
    logic       bus_off;
    logic       tx_bit;
  } core_status_s;

endpackage

// File: sim/can_bus_node.sv
// bus node model: idles recessive, pulls the wire dominant on request
`timescale 1ns/1ps
module can_bus_node (
  input  wire logic mclk,
  input  wire logic bus_tx_pin,
  output logic      bus_rx_pin
);
  logic drive_dom_q;

  // wired-and bus: any dominant driver wins
  assign bus_rx_pin = bus_tx_pin & ~drive_dom_q;

  initial drive_dom_q = 1'b0;

  task automatic pulse(input int n);
    @(posedge mclk);
    drive_dom_q <= 1'b1;
    repeat (n) @(posedge mclk);
    drive_dom_q <= 1'b0;
  endtask
endmodule

// File: sim/can_mode_monitor.sv
// port checker for the mode-control block
`timescale 1ns/1ps
`include "can_mode_consts.svh"
module can_mode_monitor
  import can_mode_pkg::*;
(
  input wire logic       mclk,
  input wire logic       srst,
  input wire reg_req_s   req,
  input wire logic       bus_tx_pin,
  input wire logic       tq_tick,
  input wire logic [2:0] resync_jump_width,
  input wire logic [3:0] phase_segment_one,
  input wire logic       abort_traffic,
  input wire logic       synced,
  input wire logic       ack_suppress,
  input wire logic       err_freeze,
  input wire logic       tx_inhibit
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  // ====
  // helper: ticks since init was left
  logic [3:0] ticks_q;
  always_ff @(posedge mclk) begin
    if (srst || abort_traffic)
      ticks_q <= 4'h0;
    else if (tq_tick && ticks_q != 4'hF)
      ticks_q <= ticks_q + 4'h1;
  end

  // ====
  // properties
  property p_init_tx;
    req.wr && req.addr == `OFS_CTL_PRIMARY && req.wdata[`CTL0_INIT_REQ]
      |-> ##[1:3] (bus_tx_pin && abort_traffic);
  endproperty
  a_init_tx: assert property (p_init_tx)
    else $error("tx pin not recessive after init request");
  property p_tx_held;
    abort_traffic [*3] |-> bus_tx_pin;
  endproperty
  a_tx_held: assert property (p_tx_held)
    else $error("tx pin left recessive in init");
  property p_quiet;
    abort_traffic [*3] |-> !synced && tx_inhibit;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("sync or transmit kept in init");
  property p_no_tick;
    abort_traffic && $past(abort_traffic) |-> !tq_tick;
  endproperty
  a_no_tick: assert property (p_no_tick)
    else $error("quantum tick in init");
  property p_jump_lock;
    $changed(resync_jump_width) |-> $past(abort_traffic);
  endproperty
  a_jump_lock: assert property (p_jump_lock)
    else $error("jump width changed outside init");
  property p_seg_lock;
    $changed(phase_segment_one) |-> $past(abort_traffic);
  endproperty
  a_seg_lock: assert property (p_seg_lock)
    else $error("segment changed outside init");
  property p_sync_run;
    $rose(synced) |-> ticks_q >= 4'hA;
  endproperty
  a_sync_run: assert property (p_sync_run)
    else $error("synced before recessive run");
  property p_listen_ack;
    err_freeze |-> ack_suppress && tx_inhibit;
  endproperty
  a_listen_ack: assert property (p_listen_ack)
    else $error("listen mode still acks or sends");

  c_sync: cover property ($rose(synced));
  c_listen: cover property ($rose(err_freeze));
  c_cfg: cover property (req.wr && abort_traffic);
endmodule

bind can_mode_ctrl can_mode_monitor u_can_mode_monitor (
  .mclk(mclk), .srst(srst), .req(req), .bus_tx_pin(bus_tx_pin),
  .tq_tick(tq_tick), .resync_jump_width(resync_jump_width),
  .phase_segment_one(phase_segment_one), .abort_traffic(abort_traffic),
  .synced(synced), .ack_suppress(ack_suppress), .err_freeze(err_freeze),
  .tx_inhibit(tx_inhibit)
);

// File: sim/testbench.sv
// self-checking bench for the mode-control and bit-timing block
`timescale 1ns/1ps
`include "can_mode_consts.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module testbench
  import can_mode_pkg::*;
();
  logic         mclk, srst, special_mode, bus_rx_pin, bus_tx_pin, rx_bit, tq_tick;
  logic         triple_sampling, clock_select, module_enable, abort_traffic;
  logic         synced, ack_suppress, err_freeze, tx_inhibit;
  logic [2:0]   resync_jump_width, phase_segment_two;
  logic [3:0]   phase_segment_one;
  logic [7:0]   rdata, d;
  reg_req_s     req;
  core_status_s core;
  int           num_errors, compares, n;

  can_mode_ctrl u_can_mode_ctrl (
    .mclk(mclk), .srst(srst), .req(req), .rdata(rdata), .core(core),
    .special_mode(special_mode), .bus_rx_pin(bus_rx_pin),
    .bus_tx_pin(bus_tx_pin), .rx_bit(rx_bit), .tq_tick(tq_tick),
    .resync_jump_width(resync_jump_width), .triple_sampling(triple_sampling),
    .phase_segment_two(phase_segment_two), .phase_segment_one(phase_segment_one),
    .clock_select(clock_select), .module_enable(module_enable),
    .abort_traffic(abort_traffic), .synced(synced), .ack_suppress(ack_suppress),
    .err_freeze(err_freeze), .tx_inhibit(tx_inhibit)
  );
  can_bus_node u_can_bus_node (
    .mclk(mclk), .bus_tx_pin(bus_tx_pin), .bus_rx_pin(bus_rx_pin)
  );

  always #25 mclk = ~mclk;

  // ====
  // bus and wait tasks
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    req.rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    `CHK(v, e)
  endtask
  // s=1 waits for sync, s=0 for a quantum tick
  task automatic wait_on(input bit s, input int lim, output int k);
    k = 0;
    do begin
      @(posedge mclk);
      #1;
      k++;
    end while ((s ? synced : tq_tick) !== 1'b1 && k < lim);
    if ((s ? synced : tq_tick) !== 1'b1) begin
      num_errors++;
      end_sim();
    end
  endtask
  task automatic end_sim();
    if (num_errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ====
  // scenarios
  task automatic t_reset();
    `CHK({bus_tx_pin, resync_jump_width, err_freeze}, 5'b10011)
    rc(`OFS_CTL_PRIMARY, `RST_CTL0);
    rc(`OFS_CTL_SECONDARY, `RST_CTL1);
    rc(`OFS_BT_PRESCALE, `RST_BT_PRESCALE);
    rc(`OFS_BT_SEGMENTS, 8'h00);
    rc(8'h0D, 8'h00);
  endtask
  task automatic t_config();
    wr(`OFS_BT_PRESCALE, 8'hC3);
    wr(`OFS_BT_SEGMENTS, 8'hA5);
    tick(2);
    `CHK(resync_jump_width, 3'h4)
    `CHK({triple_sampling, phase_segment_two, phase_segment_one}, 8'hA5)
    rc(`OFS_BT_PRESCALE, 8'hC3);
    wr(`OFS_CTL_SECONDARY, 8'h80);
    wr(`OFS_CTL_SECONDARY, 8'h40);
    tick(2);
    `CHK({module_enable, clock_select}, 2'b11)
    @(posedge mclk);
    special_mode <= 1'b1;
    core.tx_bit <= 1'b0;
    wr(`OFS_CTL_SECONDARY, 8'h20);
    tick(3);
    `CHK({module_enable, clock_select, ack_suppress, err_freeze, rx_bit}, 5'h04)
    `CHK(bus_tx_pin, 1'b1)
    wr(`OFS_CTL_SECONDARY, 8'h10);
    tick(3);
    `CHK({err_freeze, ack_suppress, tx_inhibit, rx_bit}, 4'hF)
    wr(`OFS_CTL_SECONDARY, 8'h80);
    @(posedge mclk);
    special_mode <= 1'b0;
    core.tx_bit <= 1'b1;
    core.bus_off <= 1'b1;
    tick(2);
    `CHK({module_enable, clock_select}, 2'b10)
    rc(`OFS_CTL_SECONDARY, 8'h81);
  endtask
  task automatic t_leave();
    wr(`OFS_CTL_PRIMARY, 8'h00);
    tick(3);
    rc(`OFS_CTL_SECONDARY, 8'h80);
    rc(`OFS_STATUS_EXT, 8'h03);
    wait_on(1'b0, 200, n);
    wait_on(1'b0, 200, n);
    `CHK(n, 4)
    // bus-off: 128 runs of 11 ticks of 4 cycles
    wait_on(1'b1, 7000, n);
    `CHK(n > 5560 && n < 5700, 1'b1)
  endtask
  task automatic t_sleep();
    wr(`OFS_BT_PRESCALE, 8'h00);
    rc(`OFS_BT_PRESCALE, 8'hC3);
    @(posedge mclk);
    core.bus_off <= 1'b0;
    core.tx_pending <= 1'b1;
    wr(`OFS_CTL_PRIMARY, 8'h02);
    tick(6);
    rd(`OFS_CTL_SECONDARY, d);
    `CHK(d[1], 1'b0)
    wr(`OFS_CTL_PRIMARY, 8'h00);
    rd(`OFS_CTL_PRIMARY, d);
    `CHK(d[1], 1'b1)
    @(posedge mclk);
    core.tx_pending <= 1'b0;
    tick(6);
    rd(`OFS_CTL_SECONDARY, d);
    `CHK(d[1], 1'b1)
    u_can_bus_node.pulse(3);
    tick(4);
    rd(`OFS_CTL_PRIMARY, d);
    `CHK(d[1], 1'b1)
    wr(`OFS_CTL_PRIMARY, 8'h06);
    u_can_bus_node.pulse(3);
    tick(4);
    rd(`OFS_CTL_PRIMARY, d);
    `CHK(d[2:0], 3'h4)
    rd(`OFS_CTL_SECONDARY, d);
    `CHK(d[1], 1'b0)
    wait_on(1'b1, 80, n);
  endtask
  task automatic t_reinit();
    // park in sleep first so that the init request cuts no frame
    wr(`OFS_CTL_PRIMARY, 8'h0A);
    wr(`OFS_TX_IRQ_EN, 8'h05);
    rc(`OFS_TX_IRQ_EN, 8'h05);
    tick(4);
    rd(`OFS_CTL_SECONDARY, d);
    `CHK(d[1], 1'b1)
    @(posedge mclk);
    core.tx_bit <= 1'b0;
    tick(3);
    `CHK(bus_tx_pin, 1'b0)
    // clear attempt lands before the ack can
    req <= '{addr: `OFS_CTL_PRIMARY, wdata: 8'h0D, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    req.wdata <= 8'h0C;
    @(posedge mclk);
    req.wr <= 1'b0;
    #1;
    `CHK(bus_tx_pin, 1'b1)
    tick(3);
    rd(`OFS_CTL_PRIMARY, d);
    `CHK(d[7:3], 5'h00)
    `CHK(d[2:0], 3'h5)
    rc(`OFS_TX_IRQ_EN, 8'h00);
    rd(`OFS_CTL_SECONDARY, d);
    `CHK(d[0], 1'b1)
    `CHK({abort_traffic, synced}, 2'b10)
    // leave init with a sleep request, through resync into a filtered sleep; short glitches must not wake
    wr(`OFS_CTL_SECONDARY, 8'h84);
    @(posedge mclk);
    core.tx_bit <= 1'b1;
    wr(`OFS_CTL_PRIMARY, 8'h06);
    tick(60);
    rd(`OFS_CTL_SECONDARY, d);
    `CHK(d[2:0], 3'h6)
    u_can_bus_node.pulse(3);
    tick(4);
    rd(`OFS_CTL_PRIMARY, d);
    `CHK(d[1], 1'b1)
    u_can_bus_node.pulse(45);
    tick(4);
    rd(`OFS_CTL_PRIMARY, d);
    `CHK(d[1], 1'b0)
    rc(`OFS_RX_FLAGS, 8'h80);
  endtask

  initial begin
    mclk = 1'b0;
    srst = 1'b1;
    special_mode = 1'b0;
    req = '0;
    core = '0;
    core.tx_bit = 1'b1;
    num_errors = 0;
    compares = 0;
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    tick(2);
    t_reset();
    t_config();
    t_leave();
    t_sleep();
    t_reinit();
    end_sim();
  end
endmodule
